/* File: bomsr_top.v */
`include "bomsr_regs.vh"

module bomsr_top (
  input  wire        clk,
  input  wire        reset,
  // power mode pins from the sequencer
  input  wire [1:0]  powerMode,
  // fuse contents, static after power on
  input  wire [5:0]  fuseRunCode,
  input  wire [5:0]  fuseStandbyCode,
  input  wire [5:0]  fuseSleepCode,
  input  wire        fuseRunEnable,
  input  wire        fuseStandbyEnable,
  input  wire        fuseSlewSlow,
  input  wire        fuseScalingSelect,
  // axi4-lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // regulator controls
  output reg  [5:0]  outputCode,
  output reg         buckEnable,
  output reg         lowPowerMode,
  output reg         forcedPwm,
  output reg         forcedConduction,
  output reg         rampActive
);

  reg  [5:0]  runCode_reg;
  reg  [5:0]  standbyCode_reg;
  reg  [5:0]  sleepCode_reg;
  reg  [6:0]  ctrl_reg;
  reg         fuseScalingSelect_reg;
  reg         fuseLoadPending_reg;
  reg  [11:0] awAddr_reg;
  reg         awHeld_reg;
  reg  [7:0]  wData_reg;
  reg         wLane0_reg;
  reg         wHeld_reg;
  reg  [31:0] readData_next;
  reg         readHit_next;
  reg  [5:0]  targetCode_next;
  reg         enable_next;

  wire [1:0]  modeSync;
  wire [5:0]  slewCode;
  wire        slowRate;
  wire        doWrite;
  wire [7:0]  writeIndex;
  wire        writeMapped;
  wire [7:0]  readIndex;
  wire        readMapped;
  wire        inRun;

  // mode pins cross from the sequencer domain
  bomsr_sync3 #(
    .WIDTH   (2)
  ) u_modeSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (powerMode),
    .syncOut (modeSync)
  );

  assign inRun = (modeSync != `BOMSR_MODE_STANDBY) && (modeSync != `BOMSR_MODE_SLEEP);

  // fuse level select overrides the host slew choice with the fast rate
  assign slowRate = ctrl_reg[`BOMSR_BIT_SLEW_SLOW] & ~fuseScalingSelect_reg;

  // pick the code and enable of the active power mode
  always @*
  begin
    targetCode_next = runCode_reg;
    enable_next     = ctrl_reg[`BOMSR_BIT_RUN_EN];
    case (modeSync)
      `BOMSR_MODE_STANDBY:
      begin
        targetCode_next = standbyCode_reg;
        enable_next     = ctrl_reg[`BOMSR_BIT_STBY_EN];
      end
      `BOMSR_MODE_SLEEP:
      begin
        targetCode_next = sleepCode_reg;
        enable_next     = ctrl_reg[`BOMSR_BIT_SLP_EN];
      end
      default:
      begin
        targetCode_next = runCode_reg;
        enable_next     = ctrl_reg[`BOMSR_BIT_RUN_EN];
      end
    endcase
  end

  // output follows the target one step at a time; the fuse run code loaded after reset is applied at once
  bomsr_slew u_slew (
    .clk        (clk),
    .reset      (reset),
    .load       (fuseLoadPending_reg),
    .loadCode   (fuseRunCode),
    .targetCode (targetCode_next),
    .slowRate   (slowRate),
    .outCode    (slewCode)
  );

  // regulator control outputs, all registered
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      outputCode       <= `BOMSR_CODE_RESET;
      buckEnable       <= 1'b0;
      lowPowerMode     <= 1'b0;
      forcedPwm        <= 1'b0;
      forcedConduction <= 1'b0;
      rampActive       <= 1'b0;
    end
    else
    begin
      outputCode       <= slewCode;
      buckEnable       <= enable_next & ~fuseLoadPending_reg;
      lowPowerMode     <= ctrl_reg[`BOMSR_BIT_LOW_PWR] & ~inRun;
      forcedPwm        <= ctrl_reg[`BOMSR_BIT_FORCED_PWM];
      forcedConduction <= ctrl_reg[`BOMSR_BIT_CCM_DOWN] & (slewCode > targetCode_next);
      rampActive       <= (slewCode != targetCode_next);
    end
  end

  // write path: address and data taken in either order, then one response
  assign doWrite     = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
  assign writeIndex  = awAddr_reg[9:2];
  assign writeMapped = (awAddr_reg[11:10] == 2'h0) &&
                       ((writeIndex == `BOMSR_IDX_RUN_VOLT) || (writeIndex == `BOMSR_IDX_STBY_VOLT) ||
                        (writeIndex == `BOMSR_IDX_SLP_VOLT) || (writeIndex == `BOMSR_IDX_MODE_CTRL) ||
                        (writeIndex == `BOMSR_IDX_STATUS));

  // write channel handshakes
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BOMSR_RESP_OKAY;
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= 12'h000;
      wData_reg     <= 8'h00;
      wLane0_reg    <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_reg    <= s_axi_awaddr;
        awHeld_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_reg    <= s_axi_wdata[7:0];
        wLane0_reg   <= s_axi_wstrb[0];
        wHeld_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeMapped ? `BOMSR_RESP_OKAY : `BOMSR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        awHeld_reg    <= 1'b0;
        wHeld_reg     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // fuse capture happens on the first edge after reset release
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fuseLoadPending_reg   <= 1'b1;
      fuseScalingSelect_reg <= 1'b0;
      runCode_reg           <= `BOMSR_CODE_RESET;
      standbyCode_reg       <= `BOMSR_CODE_RESET;
      sleepCode_reg         <= `BOMSR_CODE_RESET;
      ctrl_reg              <= `BOMSR_CTRL_RESET;
    end
    else if (fuseLoadPending_reg)
    begin
      fuseLoadPending_reg                 <= 1'b0;
      fuseScalingSelect_reg               <= fuseScalingSelect;
      runCode_reg                         <= fuseRunCode;
      standbyCode_reg                     <= fuseStandbyCode;
      sleepCode_reg                       <= fuseSleepCode;
      ctrl_reg[`BOMSR_BIT_RUN_EN]         <= fuseRunEnable;
      ctrl_reg[`BOMSR_BIT_STBY_EN]        <= fuseStandbyEnable;
      ctrl_reg[`BOMSR_BIT_SLEW_SLOW]      <= fuseSlewSlow;
    end
    else if (doWrite && wLane0_reg)
    begin
      // only the low six bits of a voltage word are kept
      case (writeIndex)
        `BOMSR_IDX_RUN_VOLT:  runCode_reg     <= wData_reg[5:0];
        `BOMSR_IDX_STBY_VOLT: standbyCode_reg <= wData_reg[5:0];
        `BOMSR_IDX_SLP_VOLT:  sleepCode_reg   <= wData_reg[5:0];
        `BOMSR_IDX_MODE_CTRL: ctrl_reg        <= wData_reg[6:0];
        default:              ctrl_reg        <= ctrl_reg;
      endcase
    end
  end

  // read decode; unmapped words read zero with an error answer
  assign readIndex  = s_axi_araddr[9:2];
  assign readMapped = (s_axi_araddr[11:10] == 2'h0);

  always @*
  begin
    readData_next = 32'h00000000;
    readHit_next  = readMapped;
    case (readIndex)
      `BOMSR_IDX_RUN_VOLT:  readData_next[5:0] = runCode_reg;
      `BOMSR_IDX_STBY_VOLT: readData_next[5:0] = standbyCode_reg;
      `BOMSR_IDX_SLP_VOLT:  readData_next[5:0] = sleepCode_reg;
      `BOMSR_IDX_MODE_CTRL: readData_next[6:0] = ctrl_reg;
      `BOMSR_IDX_STATUS:
      begin
        readData_next[5:0] = outputCode;
        readData_next[7:6] = modeSync;
        readData_next[8]   = rampActive;
      end
      default:              readHit_next = 1'b0;
    endcase
  end

  // read channel: one read outstanding, answer one edge after address
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `BOMSR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readHit_next ? readData_next : 32'h00000000;
      s_axi_rresp   <= readHit_next ? `BOMSR_RESP_OKAY : `BOMSR_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // bomsr_top

/* File: bomsr_regs.vh */
`ifndef BOMSR_REGS_VH
`define BOMSR_REGS_VH

// register indices; byte address is four times the index
`define BOMSR_IDX_RUN_VOLT      8'h32
`define BOMSR_IDX_STBY_VOLT     8'h33
`define BOMSR_IDX_SLP_VOLT      8'h34
`define BOMSR_IDX_MODE_CTRL     8'h40
`define BOMSR_IDX_STATUS        8'h41

// mode control field positions
`define BOMSR_BIT_RUN_EN        0
`define BOMSR_BIT_STBY_EN       1
`define BOMSR_BIT_SLP_EN        2
`define BOMSR_BIT_LOW_PWR       3
`define BOMSR_BIT_SLEW_SLOW     4
`define BOMSR_BIT_CCM_DOWN      5
`define BOMSR_BIT_FORCED_PWM    6
`define BOMSR_CTRL_WIDTH        7

// status field positions
`define BOMSR_STAT_CODE_LSB     0
`define BOMSR_STAT_MODE_LSB     6
`define BOMSR_STAT_RAMP_BIT     8

// voltage code width and reset values
`define BOMSR_CODE_WIDTH        6
`define BOMSR_CODE_RESET        6'h00
`define BOMSR_CTRL_RESET        7'h00

// power mode encodings
`define BOMSR_MODE_RUN          2'h0
`define BOMSR_MODE_STANDBY      2'h1
`define BOMSR_MODE_SLEEP        2'h2

// bus answers
`define BOMSR_RESP_OKAY         2'h0
`define BOMSR_RESP_SLVERR       2'h2

// timing: clock period and one voltage step per interval
`define BOMSR_CLK_PERIOD_NS     100
`define BOMSR_SLEW_FAST_NS      2000
`define BOMSR_SLEW_SLOW_NS      4000
`define BOMSR_SLEW_FAST_CYC     (`BOMSR_SLEW_FAST_NS / `BOMSR_CLK_PERIOD_NS)
`define BOMSR_SLEW_SLOW_CYC     (`BOMSR_SLEW_SLOW_NS / `BOMSR_CLK_PERIOD_NS)

`endif

/* File: bomsr_sync3.v */
`include "bomsr_regs.vh"

module bomsr_sync3 #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;

  // stage1 feeds stage2 only; a change counts once stages 2 and 3 agree
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
      syncOut    <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (stage2_reg == stage3_reg)
        syncOut <= stage3_reg;
    end
  end

endmodule // bomsr_sync3

/* File: bomsr_slew.v */
`include "bomsr_regs.vh"

module bomsr_slew (
  input  wire       clk,
  input  wire       reset,
  input  wire       load,
  input  wire [5:0] loadCode,
  input  wire [5:0] targetCode,
  input  wire       slowRate,
  output reg  [5:0] outCode
);

  // counts are worked out as integers, then cut to the counter width on purpose
  localparam integer FAST_INT = `BOMSR_SLEW_FAST_CYC;
  localparam integer SLOW_INT = `BOMSR_SLEW_SLOW_CYC;
  localparam [5:0]   FAST_CYC = FAST_INT[5:0];
  localparam [5:0]   SLOW_CYC = SLOW_INT[5:0];

  reg  [5:0] stepCount_reg;
  wire [5:0] period;

  assign period = slowRate ? SLOW_CYC : FAST_CYC;

  // one code step per interval; interval restarts when the target is reached
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      outCode       <= `BOMSR_CODE_RESET;
      stepCount_reg <= 6'h00;
    end
    else if (load)
    begin
      outCode       <= loadCode;
      stepCount_reg <= 6'h00;
    end
    else if (outCode == targetCode)
      stepCount_reg <= 6'h00;
    else if (stepCount_reg >= period - 6'h01)
    begin
      stepCount_reg <= 6'h00;
      if (targetCode > outCode)
        outCode <= outCode + 6'h01;
      else
        outCode <= outCode - 6'h01;
    end
    else
      stepCount_reg <= stepCount_reg + 6'h01;
  end

endmodule // bomsr_slew

/* File: bomsr_top_properties.sv */
`include "bomsr_regs.vh"
module bomsr_top_props (
  input logic        clk,
  input logic        reset,
  input logic [1:0]  powerMode,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [5:0]  outputCode,
  input logic        lowPowerMode,
  input logic        forcedConduction,
  input logic        rampActive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] postCnt;
  logic [5:0] prevCode;
  logic [7:0] gap;
  logic       hadIdle;
  wire        chg = outputCode != prevCode;
  // step spacing; an idle spell drops the claim, restart phase is free
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      postCnt <= 3'h0;
      prevCode <= 6'h00;
      gap <= 8'h00;
      hadIdle <= 1'b1;
    end
    else
    begin
      postCnt <= postCnt + {2'h0, postCnt != 3'h7};
      prevCode <= outputCode;
      gap <= chg ? 8'h00 : gap + {7'h00, gap != 8'hFF};
      hadIdle <= chg ? !rampActive : hadIdle | !rampActive;
    end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  low_power_off_a: assert property ((powerMode == `BOMSR_MODE_RUN) [*8] |=> !lowPowerMode)
    else $error("low power in run mode");
  step_size_a: assert property (chg && postCnt == 3'h7 |-> outputCode == prevCode + 6'h01 || outputCode == prevCode - 6'h01)
    else $error("code moved by more than one step");
  step_gap_a: assert property (chg && !hadIdle && postCnt == 3'h7 |-> gap >= 8'h13)
    else $error("code steps too close");
  cond_ramp_a: assert property (forcedConduction |-> rampActive || $past(rampActive))
    else $error("forced conduction outside ramp");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // bomsr_top_props
bind bomsr_top bomsr_top_props chk_u (.clk(clk), .reset(reset), .powerMode(powerMode),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .outputCode(outputCode), .lowPowerMode(lowPowerMode), .forcedConduction(forcedConduction),
  .rampActive(rampActive));

/* File: bomsr_host_model.sv */
module bomsr_host_model (
  input  logic        clk,
  output logic [11:0] s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready,
  output logic        timedOut
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, timedOut} = '0;
    s_axi_wstrb = 4'h1;
  end
  // one transfer; ready sampled at negedge, released after the taking edge
  task automatic xfer(input logic wrt, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    int n;
    logic ak;
    logic wk;
    logic dn;
    n = 0;
    dn = 0;
    @(posedge clk);
    if (wrt)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d; // host may clear enables like any other bit
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!dn && n < 200)
    begin
      @(negedge clk);
      n++;
      ak = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
      wk = s_axi_wvalid & s_axi_wready;
      dn = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
      r = wrt ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge clk);
      // released lines show garbage, not the old value
      if (ak)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        s_axi_araddr <= ~a;
      end
      if (wk)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (dn)
      begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    if (!dn)
      timedOut <= 1'b1;
  endtask
endmodule // bomsr_host_model

/* File: test_buck_one_mode_setting_regs.sv */
`include "bomsr_regs.vh"
module test_buck_one_mode_setting_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_STBY = {2'h0, `BOMSR_IDX_STBY_VOLT, 2'h0};
  localparam logic [11:0] A_SLP = {2'h0, `BOMSR_IDX_SLP_VOLT, 2'h0};
  localparam logic [11:0] A_CTRL = {2'h0, `BOMSR_IDX_MODE_CTRL, 2'h0};
  logic clk, reset, fuseScalingSelect, fuseSlewSlow, timedOut;
  logic [1:0] powerMode, bresp, rresp, r;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [5:0] outputCode;
  logic buckEnable, lowPowerMode, forcedPwm, forcedConduction, rampActive;
  int err_count, num_checks, n;
  bomsr_top dut_u (.clk(clk), .reset(reset), .powerMode(powerMode), .fuseRunCode(6'h15),
    .fuseStandbyCode(6'h0A), .fuseSleepCode(6'h2B), .fuseRunEnable(1'b1), .fuseStandbyEnable(1'b1),
    .fuseSlewSlow(fuseSlewSlow), .fuseScalingSelect(fuseScalingSelect), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .outputCode(outputCode), .buckEnable(buckEnable), .lowPowerMode(lowPowerMode),
    .forcedPwm(forcedPwm), .forcedConduction(forcedConduction), .rampActive(rampActive));
  bomsr_host_model host_u (.clk(clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timedOut(timedOut));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // any expired wait ends the run
  task bound;
    if (n >= 2000 || timedOut)
    begin
      err_count++;
      $display("[ERR] %0t wait expired", $time);
      finish_test;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, r);
  endtask
  task rd(input logic [11:0] a);
    host_u.xfer(1'b0, a, 32'h0, q, r);
  endtask
  // cycles until the applied code moves
  task wait_chg;
    logic [5:0] c;
    c = outputCode;
    n = 0;
    while (outputCode === c && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    bound;
  endtask
  task settle;
    n = 0;
    while (rampActive !== 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    bound;
  endtask
  task scen_defaults;
    rd(A_STBY);
    chk(q, 32'h0A);
    rd(A_SLP);
    chk(q, 32'h2B);
    rd(A_CTRL);
    chk(q, 32'h13);
    chk(outputCode, 6'h15);
    chk(buckEnable, 1'b1);
  endtask
  task scen_access;
    wr(A_STBY, 32'hFFFFFFC5);
    chk(r, `BOMSR_RESP_OKAY);
    rd(A_STBY);
    chk(q, 32'h05);
    wr(12'h3FC, 32'h1);
    chk(r, `BOMSR_RESP_SLVERR);
    rd(12'h3FC);
    chk(r, `BOMSR_RESP_SLVERR);
  endtask
  // slow downward ramp with forced conduction and low power
  task scen_standby;
    wr(A_CTRL, 32'h3B);
    powerMode <= `BOMSR_MODE_STANDBY;
    wait_chg;
    chk(forcedConduction, 1'b1);
    wait_chg;
    chk(n, `BOMSR_SLEW_SLOW_CYC);
    chk(lowPowerMode, 1'b1);
    settle;
    chk(outputCode, 6'h05);
    chk(buckEnable, 1'b1);
    chk(forcedConduction, 1'b0);
  endtask
  task scen_sleep;
    wr(A_CTRL, 32'h23);
    powerMode <= `BOMSR_MODE_SLEEP;
    repeat (8) @(negedge clk);
    chk(buckEnable, 1'b0);
    wr(A_CTRL, 32'h27);
    repeat (4) @(negedge clk);
    chk(buckEnable, 1'b1);
    wait_chg;
    wait_chg;
    chk(n, `BOMSR_SLEW_FAST_CYC);
    chk(forcedConduction, 1'b0);
    chk(lowPowerMode, 1'b0);
    settle;
    chk(outputCode, 6'h2B);
  endtask
  task scen_run;
    wr(A_CTRL, 32'h42);
    powerMode <= `BOMSR_MODE_RUN;
    repeat (8) @(negedge clk);
    chk(forcedPwm, 1'b1);
    chk(buckEnable, 1'b0);
    wr(A_CTRL, 32'h01);
    repeat (4) @(negedge clk);
    chk(forcedPwm, 1'b0);
    settle;
    chk(outputCode, 6'h15);
  endtask
  // second reset with the fuse select set: slow bit loaded but ignored
  task scen_fuse_select;
    @(posedge clk);
    reset <= 1'b1;
    fuseScalingSelect <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(A_CTRL);
    chk(q, 32'h13);
    wr(A_STBY, 32'h10);
    powerMode <= `BOMSR_MODE_STANDBY;
    wait_chg;
    wait_chg;
    chk(n, `BOMSR_SLEW_FAST_CYC);
  endtask
  initial
  begin
    reset = 1'b1;
    powerMode = `BOMSR_MODE_RUN;
    fuseScalingSelect = 1'b0;
    fuseSlewSlow = 1'b1;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(negedge clk);
    scen_defaults;
    scen_access;
    scen_standby;
    scen_sleep;
    scen_run;
    scen_fuse_select;
    finish_test;
  end
endmodule // test_buck_one_mode_setting_regs
